// ---- core/cbe_core.sv ----
// Purpose: executes one command at a time for branches, bit, flag, shift and load operations
// Assumes: data memory returns i_dm_rdata combinationally while o_dm.rd is high
// Notes: commands arrive over classic Wishbone; one answer cycle per access
// Summary of operation
// - branch on overflow clear to pc plus offset plus one, one or two cycles.
// - branch on global interrupt enable set, one cycle untaken, two taken.
// - branch on global interrupt enable clear, one cycle untaken, two taken.
// - set or clear one i/o register bit in two cycles, flags untouched.
// - logical left shift inserts zero at bit 0, updates z c n v, one cycle.
// - logical right shift inserts zero at bit 7, updates z c n v, one cycle.
// - rotate left takes carry into bit 0, old bit 7 to carry.
// - rotate right takes carry into bit 7, old bit 0 to carry, one cycle.
// - arithmetic right shift moves lower bits down, updates z c n v, one cycle.
// - nibble swap exchanges register halves in one cycle, flags untouched.
// - single-cycle set or clear of exactly one status flag.
// - bit store copies a register bit into the transfer flag only.
// - bit load copies the transfer flag into a register bit, flags untouched.
// - post-increment load reads at pointer then adds one, two cycles.
// - pre-decrement load subtracts one first then reads, two cycles.
// - displacement load reads at y plus displacement, pointer kept, two cycles.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
module cbe_core (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// data memory and i/o space
	output cbe_pkg::cbe_dm_req_t o_dm,
	input wire logic [7:0] i_dm_rdata
);
	typedef enum logic [1:0] {
		S_IDLE,
		S_FIRST,
		S_SECOND
	} cbe_state_t;

	logic nrst;
	cbe_state_t state;
	cbe_pkg::cbe_cmd_t cmd;
	logic [15:0] pc;
	logic [7:0] status_register;
	logic [7:0] gpr [0:31];
	logic refused;
	logic [1:0] last_cyc;
	logic [7:0] shf_res;
	logic shf_c;
	logic shf_z;
	logic shf_n;
	logic shf_v;

	cbe_rst_sync u_rst (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.o_nrst_sync(nrst)
	);

	// decoded view of the held command
	cbe_pkg::cbe_op_t op;
	logic [7:0] dst_val;
	logic [7:0] src_val;
	logic [15:0] ptr_x;
	logic [15:0] ptr_y;
	logic [2:0] bit_sel;
	logic [2:0] flag_sel;
	logic [15:0] br_target;
	logic is_branch;
	logic br_taken;
	logic is_load;
	logic is_io;
	logic [1:0] op_cycles;
	logic [15:0] ld_addr;

	assign op = cbe_pkg::cbe_op_t'(cmd.op);
	assign dst_val = gpr[cmd.dst];
	assign src_val = gpr[cmd.src];
	assign ptr_x = {gpr[cbe_pkg::PTR_X_LO + 5'h1], gpr[cbe_pkg::PTR_X_LO]};
	assign ptr_y = {gpr[cbe_pkg::PTR_Y_LO + 5'h1], gpr[cbe_pkg::PTR_Y_LO]};
	assign bit_sel = cmd.src[2:0];
	assign flag_sel = cmd.src[2:0];
	// signed seven-bit offset, then plus one
	assign br_target = pc + {{9{cmd.imm[6]}}, cmd.imm[6:0]} + 16'h0001;

	cbe_shift_unit u_shift (
		.i_op(cmd.op),
		.i_val(dst_val),
		.i_carry(status_register[cbe_pkg::SR_C]),
		.o_res(shf_res),
		.o_c(shf_c),
		.o_z(shf_z),
		.o_n(shf_n),
		.o_v(shf_v)
	);

	always_comb begin
		is_branch = 1'b0;
		br_taken = 1'b0;
		case (op)
			cbe_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
				is_branch = 1'b1;
				br_taken = !status_register[cbe_pkg::SR_V];
			end
			cbe_pkg::OP_BRANCH_IRQ_ON: begin
				is_branch = 1'b1;
				br_taken = status_register[cbe_pkg::SR_I];
			end
			cbe_pkg::OP_BRANCH_IRQ_OFF: begin
				is_branch = 1'b1;
				br_taken = !status_register[cbe_pkg::SR_I];
			end
			default: begin
				is_branch = 1'b0;
			end
		endcase
	end

	always_comb begin
		ld_addr = ptr_x;
		is_load = 1'b1;
		case (op)
			cbe_pkg::OP_LOAD_INDIRECT_X: ld_addr = ptr_x;
			cbe_pkg::OP_LOAD_INDIRECT_X_INC: ld_addr = ptr_x;
			cbe_pkg::OP_LOAD_INDIRECT_X_DEC: ld_addr = ptr_x - 16'h0001;
			cbe_pkg::OP_LOAD_INDIRECT_Y: ld_addr = ptr_y;
			cbe_pkg::OP_LOAD_INDIRECT_Y_INC: ld_addr = ptr_y;
			cbe_pkg::OP_LOAD_INDIRECT_Y_DEC: ld_addr = ptr_y - 16'h0001;
			cbe_pkg::OP_LOAD_WITH_DISPLACEMENT: ld_addr = ptr_y + {10'h000, cmd.imm[5:0]};
			default: is_load = 1'b0;
		endcase
	end

	assign is_io = (op == cbe_pkg::OP_IO_BIT_SET) || (op == cbe_pkg::OP_IO_BIT_CLEAR);
	assign op_cycles = (is_load || is_io || (is_branch && br_taken)) ?
		cbe_pkg::CYC_DOUBLE : cbe_pkg::CYC_SINGLE;

	// wishbone decode
	logic bus_req;
	logic bus_wr;
	logic cmd_fire;
	logic reg_hit;
	logic [4:0] reg_idx;

	assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign bus_wr = bus_req && i_wb_we;
	assign reg_hit = (i_wb_adr >= cbe_pkg::OFS_REG_BASE);
	assign reg_idx = i_wb_adr[6:2];
	// a command is taken only whole-word and only while idle
	assign cmd_fire = bus_wr && (i_wb_adr == cbe_pkg::OFS_CMD) && (i_wb_sel == 4'hf) &&
		(state == S_IDLE);

	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= bus_req;
		end
	end

	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (bus_req && !i_wb_we) begin
			if (i_wb_adr == cbe_pkg::OFS_CMD) begin
				o_wb_dat <= cmd;
			end else if (i_wb_adr == cbe_pkg::OFS_STATUS) begin
				o_wb_dat <= {22'h00_0000, last_cyc, 6'h00, refused, state != S_IDLE};
			end else if (i_wb_adr == cbe_pkg::OFS_PC) begin
				o_wb_dat <= {16'h0000, pc};
			end else if (i_wb_adr == cbe_pkg::OFS_STATUS_REGISTER) begin
				o_wb_dat <= {24'h00_0000, status_register};
			end else if (reg_hit) begin
				o_wb_dat <= {24'h00_0000, gpr[reg_idx]};
			end else begin
				o_wb_dat <= 32'h0000_0000;
			end
		end
	end

	// refused command flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			refused <= 1'b0;
		end else if (bus_wr && (i_wb_adr == cbe_pkg::OFS_CMD) && (state != S_IDLE)) begin
			refused <= 1'b1;
		end else if (bus_wr && (i_wb_adr == cbe_pkg::OFS_STATUS) && i_wb_sel[0] &&
			i_wb_dat[cbe_pkg::ST_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd <= '0;
		end else if (cmd_fire) begin
			cmd <= i_wb_dat;
		end
	end

	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: begin
					if (cmd_fire) begin
						state <= S_FIRST;
					end
				end
				S_FIRST: begin
					state <= (op_cycles == cbe_pkg::CYC_DOUBLE) ? S_SECOND : S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			last_cyc <= 2'h0;
		end else if (state == S_FIRST) begin
			last_cyc <= op_cycles;
		end
	end

	// program counter: bus may load it only while idle
	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			pc <= cbe_pkg::PC_RST;
		end else if (state == S_FIRST) begin
			if (is_branch && br_taken) begin
				pc <= br_target;
			end else begin
				pc <= pc + 16'h0001;
			end
		end else if (state == S_IDLE && bus_wr && i_wb_adr == cbe_pkg::OFS_PC) begin
			if (i_wb_sel[0]) begin
				pc[7:0] <= i_wb_dat[7:0];
			end
			if (i_wb_sel[1]) begin
				pc[15:8] <= i_wb_dat[15:8];
			end
		end
	end

	// status_register updates
	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			status_register <= cbe_pkg::STATUS_REGISTER_RST;
		end else if (state == S_FIRST) begin
			case (op)
				cbe_pkg::OP_SHIFT_LEFT_LOGICAL,
				cbe_pkg::OP_SHIFT_RIGHT_LOGICAL,
				cbe_pkg::OP_ROTATE_LEFT_CARRY,
				cbe_pkg::OP_ROTATE_RIGHT_CARRY,
				cbe_pkg::OP_SHIFT_RIGHT_ARITH: begin
					status_register[cbe_pkg::SR_C] <= shf_c;
					status_register[cbe_pkg::SR_Z] <= shf_z;
					status_register[cbe_pkg::SR_N] <= shf_n;
					status_register[cbe_pkg::SR_V] <= shf_v;
				end
				cbe_pkg::OP_FLAG_SET: begin
					status_register[flag_sel] <= 1'b1;
				end
				cbe_pkg::OP_FLAG_CLEAR: begin
					status_register[flag_sel] <= 1'b0;
				end
				cbe_pkg::OP_STORE_BIT_TO_TRANSFER_FLAG: begin
					// register from dst and bit from src, so any bit of any register is reachable
					status_register[cbe_pkg::SR_T] <= dst_val[bit_sel];
				end
				default: begin
					// swap, copies, loads, i/o bit ops and branches keep every flag
					status_register <= status_register;
				end
			endcase
		end else if (state == S_IDLE && bus_wr && i_wb_adr == cbe_pkg::OFS_STATUS_REGISTER &&
			i_wb_sel[0]) begin
			status_register <= i_wb_dat[7:0];
		end
	end

	// general registers and pointer pairs
	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 32; i++) begin
				gpr[i] <= cbe_pkg::GPR_RST;
			end
		end else if (state == S_FIRST) begin
			case (op)
				cbe_pkg::OP_SHIFT_LEFT_LOGICAL,
				cbe_pkg::OP_SHIFT_RIGHT_LOGICAL,
				cbe_pkg::OP_ROTATE_LEFT_CARRY,
				cbe_pkg::OP_ROTATE_RIGHT_CARRY,
				cbe_pkg::OP_SHIFT_RIGHT_ARITH,
				cbe_pkg::OP_NIBBLE_SWAP: begin
					gpr[cmd.dst] <= shf_res;
				end
				cbe_pkg::OP_LOAD_BIT_FROM_TRANSFER_FLAG: begin
					gpr[cmd.dst][bit_sel] <= status_register[cbe_pkg::SR_T];
				end
				cbe_pkg::OP_REGISTER_COPY: begin
					gpr[cmd.dst] <= src_val;
				end
				cbe_pkg::OP_REGISTER_PAIR_COPY: begin
					// pair indices are even; low bit of each index is ignored
					gpr[{cmd.dst[4:1], 1'b0}] <= gpr[{cmd.src[4:1], 1'b0}];
					gpr[{cmd.dst[4:1], 1'b1}] <= gpr[{cmd.src[4:1], 1'b1}];
				end
				cbe_pkg::OP_IMMEDIATE_LOAD: begin
					gpr[cmd.dst] <= cmd.imm;
				end
				cbe_pkg::OP_LOAD_INDIRECT_X_INC: begin
					{gpr[cbe_pkg::PTR_X_LO + 5'h1], gpr[cbe_pkg::PTR_X_LO]} <=
						ptr_x + 16'h0001;
				end
				cbe_pkg::OP_LOAD_INDIRECT_X_DEC: begin
					{gpr[cbe_pkg::PTR_X_LO + 5'h1], gpr[cbe_pkg::PTR_X_LO]} <= ld_addr;
				end
				cbe_pkg::OP_LOAD_INDIRECT_Y_INC: begin
					{gpr[cbe_pkg::PTR_Y_LO + 5'h1], gpr[cbe_pkg::PTR_Y_LO]} <=
						ptr_y + 16'h0001;
				end
				cbe_pkg::OP_LOAD_INDIRECT_Y_DEC: begin
					{gpr[cbe_pkg::PTR_Y_LO + 5'h1], gpr[cbe_pkg::PTR_Y_LO]} <= ld_addr;
				end
				default: begin
					gpr[cmd.dst] <= dst_val;
				end
			endcase
		end else if (state == S_SECOND && is_load) begin
			// read data lands after any pointer update of the first cycle
			gpr[cmd.dst] <= i_dm_rdata;
		end else if (state == S_IDLE && bus_wr && reg_hit && i_wb_sel[0]) begin
			gpr[reg_idx] <= i_wb_dat[7:0];
		end
	end

	// data memory and i/o strobes, each one cycle wide
	always_ff @(posedge i_sys_clk or negedge nrst) begin
		if (!nrst) begin
			o_dm <= '0;
		end else begin
			o_dm.rd <= 1'b0;
			o_dm.wr <= 1'b0;
			if (state == S_FIRST && is_load) begin
				o_dm.addr <= ld_addr;
				o_dm.io <= 1'b0;
				o_dm.rd <= 1'b1;
			end else if (state == S_FIRST && is_io) begin
				o_dm.addr <= {10'h000, cmd.imm[5:0]};
				o_dm.io <= 1'b1;
				o_dm.rd <= 1'b1;
			end else if (state == S_SECOND && is_io) begin
				// read-modify-write keeps the neighbouring bits of the i/o register
				o_dm.wdata <= (op == cbe_pkg::OP_IO_BIT_SET) ?
					(i_dm_rdata | (8'h01 << cmd.src[2:0])) :
					(i_dm_rdata & ~(8'h01 << cmd.src[2:0]));
				o_dm.wr <= 1'b1;
			end
		end
	end
endmodule : cbe_core

// ---- core/cbe_pkg.sv ----
// Purpose: shared constants and types for the bit, flag, shift and load execution unit
// Assumes: 20 MHz single clock, classic Wishbone slave with an 8-bit byte address
// Notes: register window offsets, status register bit positions and command layout
package cbe_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;

	// wishbone register window, byte addresses
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PC = 8'h08;
	localparam logic [7:0] OFS_STATUS_REGISTER = 8'h0c;
	localparam logic [7:0] OFS_REG_BASE = 8'h80;

	// status word fields
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_REFUSED = 1;
	localparam int unsigned ST_LAST_CYC_LSB = 8;

	// status_register bit positions
	localparam int unsigned SR_C = 0;
	localparam int unsigned SR_Z = 1;
	localparam int unsigned SR_N = 2;
	localparam int unsigned SR_V = 3;
	localparam int unsigned SR_S = 4;
	localparam int unsigned SR_H = 5;
	localparam int unsigned SR_T = 6;
	localparam int unsigned SR_I = 7;

	// reset values
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
	localparam logic [7:0] GPR_RST = 8'h00;

	// pointer pairs live in the general registers, low byte first
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;

	// cycle counts per instruction class
	localparam logic [1:0] CYC_SINGLE = 2'h1;
	localparam logic [1:0] CYC_DOUBLE = 2'h2;

	typedef enum logic [5:0] {
		OP_NOP,
		OP_BRANCH_OVERFLOW_CLEAR,
		OP_BRANCH_IRQ_ON,
		OP_BRANCH_IRQ_OFF,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_SHIFT_LEFT_LOGICAL,
		OP_SHIFT_RIGHT_LOGICAL,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_SHIFT_RIGHT_ARITH,
		OP_NIBBLE_SWAP,
		OP_FLAG_SET,
		OP_FLAG_CLEAR,
		OP_STORE_BIT_TO_TRANSFER_FLAG,
		OP_LOAD_BIT_FROM_TRANSFER_FLAG,
		OP_REGISTER_COPY,
		OP_REGISTER_PAIR_COPY,
		OP_IMMEDIATE_LOAD,
		OP_LOAD_INDIRECT_X,
		OP_LOAD_INDIRECT_X_INC,
		OP_LOAD_INDIRECT_X_DEC,
		OP_LOAD_INDIRECT_Y,
		OP_LOAD_INDIRECT_Y_INC,
		OP_LOAD_INDIRECT_Y_DEC,
		OP_LOAD_WITH_DISPLACEMENT
	} cbe_op_t;

	// command word written at OFS_CMD
	typedef struct packed {
		logic [7:0] imm;
		logic [2:0] pad_a;
		logic [4:0] src;
		logic [2:0] pad_b;
		logic [4:0] dst;
		logic [1:0] pad_c;
		logic [5:0] op;
	} cbe_cmd_t;

	// request towards data memory and i/o space
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic io;
		logic [7:0] wdata;
	} cbe_dm_req_t;
endpackage : cbe_pkg

// ---- core/cbe_rst_sync.sv ----
// Purpose: release of the active-low asynchronous reset through two flip-flops
// Assumes: i_nrst may fall at any time, its rise is resynchronised
// Notes: the first stage feeds only the second stage
`timescale 1ns/100ps
module cbe_rst_sync (
	// clock and raw reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// synchronised reset
	output logic o_nrst_sync
);
	logic stage_a;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stage_a <= 1'b0;
			o_nrst_sync <= 1'b0;
		end else begin
			stage_a <= 1'b1;
			o_nrst_sync <= stage_a;
		end
	end
endmodule : cbe_rst_sync

// ---- core/cbe_shift_unit.sv ----
// Purpose: combinational shifts, rotates and nibble swap with their flag results
// Assumes: op is one of the shift class codes, others pass the value through
// Notes: v follows n xor c for every shift, nibble swap passes carry through but still reports z n v of its result
`timescale 1ns/100ps
module cbe_shift_unit (
	// operation and operand
	input wire logic [5:0] i_op,
	input wire logic [7:0] i_val,
	input wire logic i_carry,
	// result and flags
	output logic [7:0] o_res,
	output logic o_c,
	output logic o_z,
	output logic o_n,
	output logic o_v
);
	always_comb begin
		o_res = i_val;
		o_c = i_carry;
		case (cbe_pkg::cbe_op_t'(i_op))
			cbe_pkg::OP_SHIFT_LEFT_LOGICAL: begin
				o_res = {i_val[6:0], 1'b0};
				o_c = i_val[7];
			end
			cbe_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
				o_res = {1'b0, i_val[7:1]};
				o_c = i_val[0];
			end
			cbe_pkg::OP_ROTATE_LEFT_CARRY: begin
				o_res = {i_val[6:0], i_carry};
				o_c = i_val[7];
			end
			cbe_pkg::OP_ROTATE_RIGHT_CARRY: begin
				o_res = {i_carry, i_val[7:1]};
				o_c = i_val[0];
			end
			cbe_pkg::OP_SHIFT_RIGHT_ARITH: begin
				o_res = {i_val[7], i_val[7:1]};
				o_c = i_val[0];
			end
			cbe_pkg::OP_NIBBLE_SWAP: begin
				o_res = {i_val[3:0], i_val[7:4]};
			end
			default: begin
				o_res = i_val;
			end
		endcase
		o_z = (o_res == 8'h00);
		o_n = o_res[7];
		o_v = o_n ^ o_c;
	end
endmodule : cbe_shift_unit

// ---- tb/cbe_core_checker.sv ----
// Purpose: port-level checks of the execution unit
// Assumes: commands are only written while the unit is idle
// Notes: memory timing is counted from the edge a command is taken
`timescale 1ns/100ps
module cbe_core_checker (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// wishbone
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// memory side
	input cbe_pkg::cbe_dm_req_t o_dm,
	input wire logic [7:0] i_dm_rdata
);
	logic req;
	logic go;
	logic [5:0] op;
	logic [31:0] cmd_q;
	logic [7:0] mask;
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign go = req && i_wb_we && i_wb_sel == 4'hf && i_wb_adr == cbe_pkg::OFS_CMD;
	assign op = i_wb_dat[5:0];
	assign mask = 8'h01 << cmd_q[18:16];
	// keeps the last accepted command so the i/o write can be judged later
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_q <= 32'h0;
		end else if (go) begin
			cmd_q <= i_wb_dat;
		end
	end
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	a_ack_next: assert property (req |=> o_wb_ack)
		else $error("request not acknowledged");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(req))
		else $error("ack without request");
	a_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h40 |-> o_wb_dat == 32'h0)
		else $error("unmapped read not zero");
	a_load_read: assert property (
		go && op inside {[6'h13:6'h19]} |-> ##2 o_dm.rd && !o_dm.io && !o_dm.wr)
		else $error("load read strobe misplaced");
	a_io_rmw: assert property (
		go && op inside {6'h04, 6'h05} |-> ##2 (o_dm.rd && o_dm.io) ##1 (o_dm.wr && o_dm.io))
		else $error("i/o bit access misplaced");
	a_io_data: assert property (
		o_dm.wr |-> o_dm.io && o_dm.addr == {10'h0, cmd_q[29:24]} && o_dm.wdata ==
		(cmd_q[5:0] == 6'h04 ? $past(i_dm_rdata) | mask : $past(i_dm_rdata) & ~mask))
		else $error("i/o bit write data wrong");
	a_quiet_ops: assert property (
		go && op inside {[6'h06:6'h12]} |=> (!o_dm.rd && !o_dm.wr)[*4])
		else $error("register op touched memory");
endmodule : cbe_core_checker

bind cbe_core cbe_core_checker u_chk (.i_sys_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
	.i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_dm, .i_dm_rdata);

// ---- tb/cbe_dm_model.sv ----
// Purpose: data memory and i/o space behind the execution unit
// Assumes: read data is wanted in the same cycle as the read strobe
// Notes: data space is a fixed address pattern, i/o space is writable
`timescale 1ns/100ps
module cbe_dm_model (
	// clock
	input wire logic i_sys_clk,
	// request and answer
	input cbe_pkg::cbe_dm_req_t i_dm,
	output logic [7:0] o_rdata
);
	logic [7:0] io_mem [64];
	logic [7:0] last;
	logic [7:0] cur;
	initial begin
		for (int i = 0; i < 64; i++) begin
			io_mem[i] = 8'h55 ^ 8'(i);
		end
		last = 8'h00;
	end
	// a pattern lets every address be checked without storing 64k bytes
	assign cur = i_dm.io ? io_mem[i_dm.addr[5:0]] : i_dm.addr[7:0] ^ i_dm.addr[15:8] ^ 8'h3c;
	// released bus shows the inverse of its last value, never a stale copy
	assign o_rdata = i_dm.rd ? cur : ~last;
	always @(posedge i_sys_clk) begin
		if (i_dm.rd) last <= cur;
		if (i_dm.wr && i_dm.io) io_mem[i_dm.addr[5:0]] <= i_dm.wdata;
	end
endmodule : cbe_dm_model

// ---- tb/test_cbe_core.sv ----
// Purpose: self-checking bench for the execution unit
// Assumes: one command at a time, busy polled before the next
// Notes: expected values are worked out here from the instruction behaviour
`timescale 1ns/100ps
module test_cbe_core;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	cbe_pkg::cbe_dm_req_t dm;
	logic [7:0] dm_rd;
	int bad_count = 0;
	int n_tests = 0;
	logic [31:0] st;
	logic [31:0] v;
	always #25 clk = ~clk;
	cbe_core DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_dm(dm), .i_dm_rdata(dm_rd));
	cbe_dm_model mem (.i_sys_clk(clk), .i_dm(dm), .o_rdata(dm_rd));
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		v = rdat;
		if (ack !== 1'b1) begin
			bad_count++;
			conclude();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	function automatic logic [7:0] ga(input logic [4:0] n);
		return cbe_pkg::OFS_REG_BASE | {1'b0, n, 2'b00};
	endfunction : ga
	function automatic logic [31:0] cw(input logic [5:0] o, input logic [4:0] d,
		input logic [4:0] s, input logic [7:0] i);
		return {i, 3'h0, s, 3'h0, d, 2'h0, o};
	endfunction : cw
	task automatic wsr(input logic [7:0] s);
		wb(1'b1, cbe_pkg::OFS_STATUS_REGISTER, {24'h0, s});
	endtask : wsr
	task automatic csr(input logic [7:0] s);
		wb(1'b0, cbe_pkg::OFS_STATUS_REGISTER, 32'h0);
		check(v, {24'h0, s});
	endtask : csr
	task automatic creg(input logic [4:0] n, input logic [7:0] e);
		wb(1'b0, ga(n), 32'h0);
		check(v, {24'h0, e});
	endtask : creg
	task automatic run(input logic [31:0] c, input logic [1:0] n);
		int k;
		wb(1'b1, cbe_pkg::OFS_CMD, c);
		k = 0;
		do begin
			wb(1'b0, cbe_pkg::OFS_STATUS, 32'h0);
			k++;
		end while (v[0] !== 1'b0 && k < 20);
		st = v;
		if (k >= 20) begin
			bad_count++;
			conclude();
		end
		check(32'(st[9:8]), 32'(n));
	endtask : run
	task automatic br(input logic [5:0] o, input logic [7:0] s, input logic [6:0] k,
		input logic [15:0] pc, input logic [1:0] n);
		wb(1'b1, cbe_pkg::OFS_PC, 32'h10);
		wsr(s);
		run(cw(o, 5'h0, 5'h0, {1'b0, k}), n);
		wb(1'b0, cbe_pkg::OFS_PC, 32'h0);
		check(v, {16'h0, pc});
	endtask : br
	task automatic sh(input logic [7:0] x, input logic c);
		logic [7:0] r;
		logic co;
		logic [7:0] s0;
		for (logic [5:0] o = 6'h06; o <= 6'h0b; o++) begin
			s0 = 8'ha6 | {7'h0, c};
			wb(1'b1, ga(5'h4), {24'h0, x});
			wsr(s0);
			case (o)
				6'h06: {co, r} = {x, 1'b0};
				6'h07: {r, co} = {1'b0, x};
				6'h08: {co, r} = {x, c};
				6'h09: {r, co} = {c, x};
				6'h0a: {r, co} = {x[7], x};
				default: {co, r} = {c, x[3:0], x[7:4]};
			endcase
			run(cw(o, 5'h4, 5'h0, 8'h0), 2'h1);
			creg(5'h4, r);
			csr(o == 6'h0b ? s0 : {s0[7:4], r[7] ^ co, r[7], r == 8'h00, co});
		end
	endtask : sh
	task automatic flags;
		for (int i = 0; i < 8; i++) begin
			wsr(8'h00);
			run(cw(6'h0c, 5'h0, 5'(i), 8'h0), 2'h1);
			csr(8'h01 << i);
			wsr(8'hff);
			run(cw(6'h0d, 5'h0, 5'(i), 8'h0), 2'h1);
			csr(~(8'h01 << i));
		end
	endtask : flags
	task automatic bits;
		wb(1'b1, ga(5'h3), 32'h20);
		wsr(8'h00);
		run(cw(6'h0e, 5'h3, 5'h5, 8'h0), 2'h1);
		csr(8'h40);
		wsr(8'hff);
		run(cw(6'h0e, 5'h3, 5'h4, 8'h0), 2'h1);
		csr(8'hbf);
		wb(1'b1, ga(5'h4), 32'hff);
		run(cw(6'h0f, 5'h4, 5'h0, 8'h0), 2'h1);
		creg(5'h4, 8'hfe);
		wsr(8'h40);
		run(cw(6'h0f, 5'h4, 5'h0, 8'h0), 2'h1);
		creg(5'h4, 8'hff);
		csr(8'h40);
	endtask : bits
	task automatic copies;
		wb(1'b1, ga(5'h2), 32'h11);
		wb(1'b1, ga(5'h3), 32'h22);
		wsr(8'h5a);
		run(cw(6'h10, 5'h6, 5'h3, 8'h0), 2'h1);
		run(cw(6'h11, 5'h8, 5'h2, 8'h0), 2'h1);
		run(cw(6'h12, 5'ha, 5'h0, 8'ha5), 2'h1);
		creg(5'h6, 8'h22);
		creg(5'h8, 8'h11);
		creg(5'h9, 8'h22);
		creg(5'ha, 8'ha5);
		csr(8'h5a);
	endtask : copies
	task automatic ld(input logic [5:0] o, input logic [4:0] lo, input logic [15:0] p,
		input logic [5:0] q, input logic [15:0] ea, input logic [15:0] ep);
		wb(1'b1, ga(lo), {24'h0, p[7:0]});
		wb(1'b1, ga(lo + 5'h1), {24'h0, p[15:8]});
		run(cw(o, 5'h1, 5'h0, {2'h0, q}), 2'h2);
		creg(5'h1, ea[7:0] ^ ea[15:8] ^ 8'h3c);
		creg(lo, ep[7:0]);
		creg(lo + 5'h1, ep[15:8]);
	endtask : ld
	task automatic io(input logic [5:0] o, input logic [2:0] b, input logic [7:0] e);
		run(cw(o, 5'h0, {2'h0, b}, 8'h21), 2'h2);
		repeat (3) @(posedge clk);
		check(32'(mem.io_mem[33]), 32'(e));
	endtask : io
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		wb(1'b0, cbe_pkg::OFS_PC, 32'h0);
		check(v, 32'h0);
		csr(8'h00);
		creg(5'h1f, 8'h00);
		wb(1'b0, 8'h40, 32'h0);
		check(v, 32'h0);
		br(6'h01, 8'h00, 7'h05, 16'h0016, 2'h2);
		br(6'h01, 8'h08, 7'h05, 16'h0011, 2'h1);
		br(6'h02, 8'h80, 7'h7e, 16'h000f, 2'h2);
		br(6'h02, 8'h7f, 7'h7e, 16'h0011, 2'h1);
		br(6'h03, 8'h7f, 7'h40, 16'hffd1, 2'h2);
		br(6'h03, 8'h80, 7'h40, 16'h0011, 2'h1);
		sh(8'h81, 1'b1);
		sh(8'h40, 1'b0);
		sh(8'h80, 1'b0);
		flags();
		bits();
		copies();
		wsr(8'h5a);
		ld(6'h13, cbe_pkg::PTR_X_LO, 16'h0abc, 6'h00, 16'h0abc, 16'h0abc);
		ld(6'h14, cbe_pkg::PTR_X_LO, 16'h01ff, 6'h00, 16'h01ff, 16'h0200);
		ld(6'h15, cbe_pkg::PTR_X_LO, 16'h0100, 6'h00, 16'h00ff, 16'h00ff);
		ld(6'h16, cbe_pkg::PTR_Y_LO, 16'h1234, 6'h00, 16'h1234, 16'h1234);
		ld(6'h17, cbe_pkg::PTR_Y_LO, 16'hffff, 6'h00, 16'hffff, 16'h0000);
		ld(6'h18, cbe_pkg::PTR_Y_LO, 16'h0000, 6'h00, 16'hffff, 16'hffff);
		ld(6'h19, cbe_pkg::PTR_Y_LO, 16'h0200, 6'h3f, 16'h023f, 16'h0200);
		csr(8'h5a);
		io(6'h04, 3'h3, 8'h7c);
		io(6'h05, 3'h2, 8'h78);
		csr(8'h5a);
		conclude();
	end
endmodule : test_cbe_core
